/* File: sca_pkg.sv */
// constants, offsets and defaults for the service counter and fault annunciator
package sca_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam longint CLK_HZ = 25_000_000;
  localparam longint HOLD_MS = 3000;
  localparam longint HOUR_S = 3600;
  localparam longint BLINK_HALF_MS = 500;
  localparam longint MSG_MS = 3000;
  localparam longint RESTART_WIN_MS = 10000;
  localparam longint HOLD_CYC_DEF = (CLK_HZ * HOLD_MS + 999) / 1000;
  localparam longint HOUR_CYC_DEF = CLK_HZ * HOUR_S;
  localparam longint BLINK_CYC_DEF = (CLK_HZ * BLINK_HALF_MS) / 1000;
  localparam longint MSG_CYC_DEF = (CLK_HZ * MSG_MS) / 1000;
  localparam longint RESTART_CYC_DEF = (CLK_HZ * RESTART_WIN_MS) / 1000;
  localparam int TW = 40;
  // ------------------------------------------------------------
  // sizes and limits
  // ------------------------------------------------------------
  localparam int NUM_SVC = 8;
  localparam int NUM_FATAL = 8;
  localparam int NUM_NONFATAL = 8;
  localparam int ERR_DEPTH = 30;
  localparam logic [13:0] LIMIT_MAX = 14'h270f;
  localparam logic [13:0] LIMIT_RST [NUM_SVC] = '{14'h0bb8, 14'h0bb8, 14'h0bb8, 14'h1770,
                                                  14'h0000, 14'h0000, 14'h0000, 14'h0000};
  localparam logic [7:0] ACTIVE_RST = 8'h3f;
  // resting contact levels: separator closed, others open
  localparam logic [4:0] REST_RST = 5'h08;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_SEL = 12'h008;
  localparam logic [11:0] OFS_ERRIDX = 12'h00c;
  localparam logic [11:0] OFS_ERRDAT = 12'h010;
  localparam logic [11:0] OFS_STARTS = 12'h020;
  localparam logic [11:0] OFS_YOPEN = 12'h024;
  localparam logic [11:0] OFS_WARR = 12'h028;
  localparam logic [11:0] OFS_LOADED = 12'h02c;
  localparam logic [11:0] OFS_LIMIT = 12'h100;
  localparam logic [11:0] OFS_ACC = 12'h140;
  // ctrl fields
  localparam int CB_AUTO = 0;
  localparam int CB_EXT = 1;
  localparam int CB_SERVICE = 2;
  localparam int CB_ERRCLR = 3;
  localparam int CB_REST = 8;
  // error codes shown on the message line
  localparam logic [7:0] CODE_FATAL = 8'h01;
  localparam logic [7:0] CODE_NONFATAL = 8'h40;
  localparam logic [7:0] CODE_SVC = 8'h60;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sca_pkg

/* File: sca_plant.sv */
// plant model: compressor machinery reacting to the motor command
module sca_plant (
  input wire logic aclk,
  input wire logic motor_enable,
  input wire logic load,
  output logic compressing = 1'b0,
  output logic idle_running = 1'b0,
  output logic y_valve_open = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // machinery lags the command by one cycle, like a contactor
  always_ff @(posedge aclk) begin
    compressing <= motor_enable & load;
    idle_running <= motor_enable & ~load;
    y_valve_open <= motor_enable & load;
  end
endmodule : sca_plant

/* File: sca_top.sv */
// service counters, operating tallies and fault annunciation with axi4-lite registers
// ------------------------------------------------------------
// top module
// ------------------------------------------------------------
// Notes on behaviour
// - eight service counters, six fixed, two general ones start inactive.
// - each counter hour limit settable from 0 to 9999.
// - hour counters advance only while compressing or idling.
// - hour limit and date limit checked independently.
// - reaching either limit raises a non-critical error and message.
// - limit 0000 disables hours, year 00 disables date check.
// - cancel key held over three seconds clears selected counter and date.
// - four tallies from zero: starts, y-valve openings, warranty, loaded hours.
// - any active error pulses maintenance lamp and shows a message.
// - fatal error without external control toggles fault blink at 1 Hz.
// - fault line low while a fatal error is active.
// - error stays latched until cause gone and confirm key pressed.
// - errors recorded in a list, erased only with service access.
// - any fatal error switches the compressor off at once.
// - fatal cause gone quickly with auto restart on restarts compressor.
// - no restart while any critical error remains active.
// - non-fatal errors only inform, never stop the compressor.
// - inverter fault shows its number, decoded per inverter type.
// - event shows a message for seconds, then display returns.
// - separator rests closed, other binary inputs rest open.
// - error list holds the thirty latest errors.
// - auto restart only when enabled, disabled after reset.
// - active level of each binary input is configurable.
module sca_top
  import sca_pkg::*;
#(
  parameter logic [sca_pkg::TW-1:0] HOLD_CYC = sca_pkg::TW'(sca_pkg::HOLD_CYC_DEF),
  parameter logic [sca_pkg::TW-1:0] HOUR_CYC = sca_pkg::TW'(sca_pkg::HOUR_CYC_DEF),
  parameter logic [sca_pkg::TW-1:0] BLINK_CYC = sca_pkg::TW'(sca_pkg::BLINK_CYC_DEF),
  parameter logic [sca_pkg::TW-1:0] MSG_CYC = sca_pkg::TW'(sca_pkg::MSG_CYC_DEF),
  parameter logic [sca_pkg::TW-1:0] RESTART_CYC = sca_pkg::TW'(sca_pkg::RESTART_CYC_DEF)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic compressing,
  input wire logic idle_running,
  input wire logic run_request,
  input wire logic y_valve_open,
  input wire logic [4:0] sensor_raw,
  input wire logic [sca_pkg::NUM_FATAL-2:0] fatal_cause_in,
  input wire logic [sca_pkg::NUM_NONFATAL-5:0] nonfatal_cause_in,
  input wire logic inverter_fault,
  input wire logic inverter_type,
  input wire logic [3:0] inverter_code,
  input wire logic event_strobe,
  input wire logic [7:0] event_code,
  input wire logic [15:0] cur_date,
  input wire logic cancel_key,
  input wire logic confirm_key,
  output logic motor_enable,
  output logic maintenance_lamp,
  output logic fault_blink,
  output logic fault_n,
  output logic [7:0] msg_id,
  output logic [4:0] inv_name_idx
);
  import sca_pkg::*;
  localparam int NE = NUM_FATAL + NUM_NONFATAL + NUM_SVC;

  logic [31:0] ctrl_reg;
  logic [2:0] sel_reg;
  logic [4:0] erridx_reg;
  logic [31:0] tally_reg [4];
  logic [13:0] lim_reg [NUM_SVC];
  logic [15:0] date_reg [NUM_SVC];
  logic [NUM_SVC-1:0] act_reg;
  logic [15:0] acc_reg [NUM_SVC];
  logic [NUM_FATAL-1:0] fat_reg;
  logic [NUM_NONFATAL-1:0] nf_reg;
  logic [NUM_SVC-1:0] svc_reg;
  logic [NE-1:0] prev_reg;
  logic [7:0] elist [ERR_DEPTH];
  logic [4:0] wptr_reg;
  logic [5:0] ecnt_reg;
  logic [TW-1:0] hour_pre_reg, load_pre_reg, hold_reg, blink_cnt_reg, msg_cnt_reg, rst_win_reg;
  logic hold_done_reg, blink_reg, conf_prev_reg, motor_prev_reg, y_prev_reg;
  logic [7:0] evt_reg;
  logic wr_en, rd_en;
  logic [31:0] wmask, rd_val;
  logic rd_ok, wr_ok;
  logic [4:0] sens_act;
  logic [NUM_FATAL-1:0] fat_cause;
  logic [NUM_NONFATAL-1:0] nf_cause;
  logic [NUM_SVC-1:0] exceeded;
  logic active_run, hour_tick, load_tick, conf_pulse, svc_clear, any_fatal, any_err;
  logic [NE-1:0] err_vec;
  logic [7:0] new_code, err_code, msg_next;
  logic new_err;

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  assign wr_en = awvalid && wvalid && !awready && !bvalid;
  assign rd_en = arvalid && !arready && !rvalid;
  assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      awready <= wr_en;
      wready <= wr_en;
      if (wr_en) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else begin
      arready <= rd_en;
      if (rd_en) begin
        rvalid <= 1'b1;
        rdata <= rd_val;
        rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_ok = (awaddr == OFS_CTRL) || (awaddr == OFS_SEL) || (awaddr == OFS_ERRIDX) ||
            (awaddr[11:5] == OFS_STARTS[11:5] && awaddr[4] == 1'b0 && awaddr[1:0] == 2'h0) ||
            (awaddr[11:5] == OFS_LIMIT[11:5] && awaddr[1:0] == 2'h0);
    rd_ok = 1'b1;
    rd_val = 32'h0;
    case (araddr)
      OFS_CTRL: rd_val = ctrl_reg;
      OFS_STATUS: rd_val = {svc_reg, nf_reg, fat_reg, 5'h0, any_err, run_request && !any_fatal, motor_enable};
      OFS_SEL: rd_val = {29'h0, sel_reg};
      OFS_ERRIDX: rd_val = {26'h0, ecnt_reg};
      OFS_ERRDAT: rd_val = {24'h0, elist[erridx_reg]};
      default: begin
        if (araddr[11:4] == OFS_STARTS[11:4] && araddr[1:0] == 2'h0) begin
          rd_val = tally_reg[araddr[3:2]];
        end else if (araddr[11:5] == OFS_LIMIT[11:5] && araddr[1:0] == 2'h0) begin
          rd_val = {date_reg[araddr[4:2]], act_reg[araddr[4:2]], 1'b0, lim_reg[araddr[4:2]]};
        end else if (araddr[11:5] == OFS_ACC[11:5] && araddr[1:0] == 2'h0) begin
          rd_val = {16'h0, acc_reg[araddr[4:2]]};
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= {19'h0, REST_RST, 8'h0};
      sel_reg <= 3'h0;
      erridx_reg <= 5'h0;
    end else if (wr_en) begin
      if (awaddr == OFS_CTRL) begin
        ctrl_reg <= ((ctrl_reg & ~wmask) | (wdata & wmask)) & 32'h00001f07;
      end
      if (awaddr == OFS_SEL && wstrb[0]) begin
        sel_reg <= wdata[2:0];
      end
      if (awaddr == OFS_ERRIDX && wstrb[0] && wdata[4:0] < 5'(ERR_DEPTH)) begin
        erridx_reg <= wdata[4:0];
      end
    end
  end

  // ------------------------------------------------------------
  // binary inputs and error causes
  // ------------------------------------------------------------
  // contact differs from resting level
  // resting level per input from ctrl
  assign sens_act = sensor_raw ^ ctrl_reg[CB_REST+:5];
  assign fat_cause = {fatal_cause_in, sens_act[0]};
  assign nf_cause = {nonfatal_cause_in, sens_act[4:1]};
  assign conf_pulse = confirm_key && !conf_prev_reg;
  assign any_fatal = |fat_reg;
  assign any_err = any_fatal || (|nf_reg) || (|svc_reg);
  assign err_vec = {svc_reg, nf_reg, fat_reg};

  // latched until cause gone and confirm; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fat_reg <= '0;
      nf_reg <= '0;
      svc_reg <= '0;
      conf_prev_reg <= 1'b0;
      rst_win_reg <= '0;
    end else begin
      conf_prev_reg <= confirm_key;
      nf_reg <= nf_cause | (conf_pulse ? (nf_reg & nf_cause) : nf_reg);
      svc_reg <= exceeded | (conf_pulse ? (svc_reg & exceeded) : svc_reg);
      // quick recovery with auto restart drops the latch
      if (any_fatal && fat_cause == '0 && ctrl_reg[CB_AUTO] && rst_win_reg < RESTART_CYC) begin
        fat_reg <= '0;
      end else begin
        fat_reg <= fat_cause | (conf_pulse ? (fat_reg & fat_cause) : fat_reg);
      end
      rst_win_reg <= any_fatal ? ((rst_win_reg < RESTART_CYC) ? rst_win_reg + 1'b1 : rst_win_reg) : '0;
    end
  end

  // ------------------------------------------------------------
  // compressor enable
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motor_enable <= 1'b0;
    end else begin
      motor_enable <= run_request && !any_fatal && fat_cause == '0;
    end
  end

  // ------------------------------------------------------------
  // hour prescalers and counters
  // ------------------------------------------------------------
  // only compressing or idle time counts
  assign active_run = compressing || idle_running;
  // one tick per full hour of active time
  assign hour_tick = active_run && hour_pre_reg == HOUR_CYC - 1'b1;
  assign load_tick = y_valve_open && load_pre_reg == HOUR_CYC - 1'b1;
  assign svc_clear = cancel_key && !hold_done_reg && hold_reg == HOLD_CYC - 1'b1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hour_pre_reg <= '0;
      load_pre_reg <= '0;
    end else begin
      // fractional hours are kept across stops
      if (active_run) begin
        hour_pre_reg <= hour_tick ? '0 : hour_pre_reg + 1'b1;
      end
      if (y_valve_open) begin
        load_pre_reg <= load_tick ? '0 : load_pre_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_reg <= '0;
      hold_done_reg <= 1'b0;
    end else if (!cancel_key) begin
      hold_reg <= '0;
      hold_done_reg <= 1'b0;
    end else begin
      // hold time measured, one clear per hold
      hold_reg <= svc_clear ? hold_reg : hold_reg + 1'b1;
      if (svc_clear) begin
        hold_done_reg <= 1'b1;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SVC; gi++) begin : g_svc
      // zero limit or zero year disables
      assign exceeded[gi] = act_reg[gi] && ((lim_reg[gi] != 14'h0 && acc_reg[gi] >= {2'h0, lim_reg[gi]}) ||
                            (date_reg[gi][15:8] != 8'h0 && cur_date >= date_reg[gi]));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          // six fixed counters active, two idle
          act_reg[gi] <= ACTIVE_RST[gi];
          lim_reg[gi] <= LIMIT_RST[gi];
          date_reg[gi] <= 16'h0;
          acc_reg[gi] <= 16'h0;
        end else begin
          if (svc_clear && sel_reg == 3'(gi)) begin
            acc_reg[gi] <= 16'h0;
            date_reg[gi] <= 16'h0;
          end else begin
            if (hour_tick && act_reg[gi] && acc_reg[gi] != 16'hffff) begin
              acc_reg[gi] <= acc_reg[gi] + 1'b1;
            end
            if (wr_en && awaddr == OFS_LIMIT + 12'(4 * gi)) begin
              if (wstrb[3] && wstrb[2]) begin
                date_reg[gi] <= wdata[31:16];
              end
              if (wstrb[1] && wstrb[0]) begin
                act_reg[gi] <= wdata[15];
                if (wdata[13:0] <= LIMIT_MAX) begin
                  lim_reg[gi] <= wdata[13:0];
                end
              end
            end
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // operating tallies
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        tally_reg[i] <= 32'h0;
      end
      motor_prev_reg <= 1'b0;
      y_prev_reg <= 1'b0;
    end else begin
      motor_prev_reg <= motor_enable;
      y_prev_reg <= y_valve_open;
      // starts, openings, warranty and loaded hours
      tally_reg[0] <= tally_reg[0] + {31'h0, motor_enable && !motor_prev_reg};
      tally_reg[1] <= tally_reg[1] + {31'h0, y_valve_open && !y_prev_reg};
      tally_reg[2] <= tally_reg[2] + {31'h0, hour_tick};
      tally_reg[3] <= tally_reg[3] + {31'h0, load_tick};
      // service may overwrite a tally
      if (wr_en && ctrl_reg[CB_SERVICE] && awaddr[11:4] == OFS_STARTS[11:4] && awaddr[1:0] == 2'h0) begin
        tally_reg[awaddr[3:2]] <= (tally_reg[awaddr[3:2]] & ~wmask) | (wdata & wmask);
      end
    end
  end

  // ------------------------------------------------------------
  // error list
  // ------------------------------------------------------------
  // lowest new error wins; simultaneous onsets beyond it are not listed
  always_comb begin
    new_err = 1'b0;
    new_code = 8'h0;
    for (int i = NE - 1; i >= 0; i--) begin
      if (err_vec[i] && !prev_reg[i]) begin
        new_err = 1'b1;
        new_code = (i < NUM_FATAL) ? CODE_FATAL + 8'(i) :
                   (i < NUM_FATAL + NUM_NONFATAL) ? CODE_NONFATAL + 8'(i - NUM_FATAL) :
                   CODE_SVC + 8'(i - NUM_FATAL - NUM_NONFATAL);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= '0;
      wptr_reg <= 5'h0;
      ecnt_reg <= 6'h0;
      for (int i = 0; i < ERR_DEPTH; i++) begin
        elist[i] <= 8'h0;
      end
    end else begin
      prev_reg <= err_vec;
      if (wr_en && awaddr == OFS_CTRL && wstrb[0] && wdata[CB_ERRCLR] && ctrl_reg[CB_SERVICE]) begin
        // an onset in the clearing cycle is kept as the first entry
        if (new_err) begin
          elist[0] <= new_code;
        end
        wptr_reg <= new_err ? 5'h1 : 5'h0;
        ecnt_reg <= new_err ? 6'h1 : 6'h0;
      end else if (new_err) begin
        elist[wptr_reg] <= new_code;
        wptr_reg <= (wptr_reg == 5'(ERR_DEPTH - 1)) ? 5'h0 : wptr_reg + 1'b1;
        if (ecnt_reg != 6'(ERR_DEPTH)) begin
          ecnt_reg <= ecnt_reg + 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // lamps, status lines and display
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b0;
      maintenance_lamp <= 1'b0;
      fault_blink <= 1'b0;
      fault_n <= 1'b1;
    end else begin
      blink_cnt_reg <= (blink_cnt_reg == BLINK_CYC - 1'b1) ? '0 : blink_cnt_reg + 1'b1;
      if (blink_cnt_reg == BLINK_CYC - 1'b1) begin
        blink_reg <= !blink_reg;
      end
      maintenance_lamp <= any_err && blink_reg;
      // 1 hz blink unless external control
      fault_blink <= any_fatal && !ctrl_reg[CB_EXT] && blink_reg;
      fault_n <= !any_fatal;
    end
  end

  always_comb begin
    err_code = 8'h0;
    for (int i = NE - 1; i >= 0; i--) begin
      if (err_vec[i]) begin
        err_code = (i < NUM_FATAL) ? CODE_FATAL + 8'(i) :
                   (i < NUM_FATAL + NUM_NONFATAL) ? CODE_NONFATAL + 8'(i - NUM_FATAL) :
                   CODE_SVC + 8'(i - NUM_FATAL - NUM_NONFATAL);
      end
    end
    // event message overlays, then prior view returns
    msg_next = (msg_cnt_reg != '0) ? evt_reg : err_code;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msg_cnt_reg <= '0;
      evt_reg <= 8'h0;
      msg_id <= 8'h0;
      inv_name_idx <= 5'h0;
    end else begin
      if (event_strobe) begin
        msg_cnt_reg <= MSG_CYC;
        evt_reg <= event_code;
      end else if (msg_cnt_reg != '0) begin
        msg_cnt_reg <= msg_cnt_reg - 1'b1;
      end
      msg_id <= msg_next;
      // code plus type selects one of 32 names
      inv_name_idx <= inverter_fault ? {inverter_type, inverter_code} : 5'h0;
    end
  end
endmodule : sca_top

/* File: sca_top_props.sv */
// port assertions for the service counter and fault annunciator
module sca_top_props
  import sca_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic wvalid,
  input wire logic awready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [sca_pkg::NUM_FATAL-2:0] fatal_cause_in,
  input wire logic inverter_fault,
  input wire logic inverter_type,
  input wire logic [3:0] inverter_code,
  input wire logic event_strobe,
  input wire logic [7:0] event_code,
  input wire logic motor_enable,
  input wire logic fault_blink,
  input wire logic fault_n,
  input wire logic [7:0] msg_id,
  input wire logic [4:0] inv_name_idx
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // assertions
  // ----
  AST_FAULT_LOW: assert property (|fatal_cause_in |=> ##1 !fault_n)
    else $error("fault line not low after fatal cause");
  AST_MOTOR_OFF: assert property (|fatal_cause_in |=> !motor_enable)
    else $error("motor still enabled after fatal cause");
  AST_NO_RESTART: assert property (!fault_n |-> !motor_enable)
    else $error("motor enabled while fatal latched");
  AST_BLINK_QUIET: assert property (fault_n |-> !fault_blink)
    else $error("fault blink without fatal error");
  AST_INV_NAME: assert property (inverter_fault |=> inv_name_idx == {$past(inverter_type), $past(inverter_code)})
    else $error("inverter name index wrong");
  AST_INV_IDLE: assert property (!inverter_fault |=> inv_name_idx == 5'h00)
    else $error("inverter name index without fault");
  AST_EVENT_MSG: assert property (event_strobe |=> ##1 msg_id == $past(event_code, 2))
    else $error("event message not shown");
  AST_WR_ANSWER: assert property (awvalid && wvalid && !awready && !bvalid |=> awready && bvalid)
    else $error("write not answered");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  // main scenarios reached
  cover property (!fault_n);
  cover property ($rose(fault_blink));
  cover property (event_strobe);
endmodule : sca_top_props

bind sca_top sca_top_props u_props (
  .aclk, .aresetn, .awvalid, .wvalid, .awready, .bvalid, .bready, .fatal_cause_in, .inverter_fault,
  .inverter_type, .inverter_code, .event_strobe, .event_code, .motor_enable, .fault_blink, .fault_n,
  .msg_id, .inv_name_idx
);

/* File: tb_top.sv */
// self-checking bench for the service counter and fault annunciator
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sca_pkg::*;
  logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic awready, wready, bvalid, arready, rvalid, motor_enable, maintenance_lamp, fault_blink, fault_n;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rv, h;
  logic [3:0] wstrb = 4'hf, nonfatal_cause_in = '0, inverter_code = '0;
  logic [1:0] bresp, rresp;
  logic run_request = '0, load = 1'b1, inverter_fault = '0, inverter_type = '0, event_strobe = '0;
  logic cancel_key = '0, confirm_key = '0, compressing, idle_running, y_valve_open;
  logic [4:0] sensor_raw = 5'h08, inv_name_idx;
  logic [6:0] fatal_cause_in = '0;
  logic [7:0] event_code = '0, msg_id;
  logic [15:0] cur_date = 16'h0600;
  int n_errors = 0, comparisons = 0, cyc = 0, nl, nb;
  // short counts keep the run brief
  sca_top #(.HOLD_CYC(40'h14), .HOUR_CYC(40'ha), .BLINK_CYC(40'h4), .MSG_CYC(40'h8), .RESTART_CYC(40'h10)) dut (.*);
  sca_plant plant (.*);
  initial forever #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  // ----
  // tasks
  // ----
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) begin
        awvalid <= 1'b0;
        wvalid <= 1'b0;
      end
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", RESP_OKAY, bresp);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rv = rdata;
  endtask : rd
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, rv);
  endtask : rc
  task automatic watch;
    logic pl, pb;
    nl = 0;
    nb = 0;
    repeat (16) begin
      pl = maintenance_lamp;
      pb = fault_blink;
      @(posedge aclk);
      nl += int'(maintenance_lamp !== pl);
      nb += int'(fault_blink !== pb);
    end
  endtask : watch
  task automatic press(input int n);
    cancel_key <= 1'b1;
    tick(n);
    cancel_key <= 1'b0;
    tick(2);
  endtask : press
  task automatic push;
    confirm_key <= 1'b1;
    tick(2);
    confirm_key <= 1'b0;
    tick(2);
  endtask : push
  // ----
  // sequence
  // ----
  initial begin
    tick(3);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rc(OFS_LIMIT + 12'(4 * i), {16'h0000, ACTIVE_RST[i], 1'b0, LIMIT_RST[i]});
    rc(OFS_CTRL, 32'h800);
    for (int i = 0; i < 4; i++) rc(OFS_STARTS + 12'(4 * i), '0);
    rd(OFS_STATUS);
    chk("idle status", '0, rv[31:8]);
    rd(12'h030);
    chk("unmapped", RESP_SLVERR, rresp);
    wr(OFS_LIMIT, 32'ha70f);
    wr(OFS_LIMIT, 32'ha710);
    rc(OFS_LIMIT, 32'ha70f);
    wr(OFS_LIMIT + 12'h4, 32'h8003);
    wr(OFS_LIMIT + 12'h8, 32'h8000);
    wr(OFS_LIMIT + 12'hc, 32'h0500_8000);
    run_request <= 1'b1;
    tick(56);
    run_request <= 1'b0;
    tick(4);
    rd(OFS_ACC);
    h = rv;
    chk("hours", 1'b1, h >= 4 && h <= 6);
    tick(40);
    rc(OFS_ACC, h);
    rc(OFS_STARTS, 32'h1);
    rc(OFS_YOPEN, 32'h1);
    rd(OFS_STATUS);
    chk("exceeded", 8'h0a, rv[31:24]);
    chk("svc msg", CODE_SVC + 8'h01, msg_id);
    watch();
    chk("lamp", 1'b1, nl >= 2);
    wr(OFS_SEL, 32'h3);
    rd(OFS_ACC + 12'hc);
    h = rv;
    press(10);
    rc(OFS_ACC + 12'hc, h);
    press(30);
    rc(OFS_ACC + 12'hc, '0);
    rc(OFS_LIMIT + 12'hc, 32'h8000);
    sensor_raw <= 5'h00;
    tick(3);
    sensor_raw <= 5'h08;
    wr(OFS_CTRL, 32'ha00);
    rd(OFS_STATUS);
    chk("separator open", 1'b1, rv[18]);
    chk("rest level", 1'b1, rv[16]);
    wr(OFS_CTRL, 32'h800);
    run_request <= 1'b1;
    tick(4);
    fatal_cause_in <= 7'h01;
    tick(4);
    rd(OFS_STATUS);
    chk("fatal latch", 8'h02, rv[15:8]);
    chk("motor off", 1'b0, motor_enable);
    chk("fatal msg", CODE_FATAL + 8'h01, msg_id);
    watch();
    chk("blink", 1'b1, nb >= 2);
    push();
    chk("cause held", 1'b0, fault_n);
    fatal_cause_in <= '0;
    tick(24);
    chk("no auto", 1'b0, fault_n);
    push();
    chk("confirmed", 1'b1, fault_n);
    chk("restarted", 1'b1, motor_enable);
    rd(OFS_STATUS);
    chk("svc kept", 8'h02, rv[31:24]);
    wr(OFS_CTRL, 32'h802);
    fatal_cause_in <= 7'h01;
    watch();
    chk("ext blink", '0, nb);
    fatal_cause_in <= '0;
    tick(2);
    push();
    wr(OFS_CTRL, 32'h801);
    fatal_cause_in <= 7'h01;
    tick(3);
    fatal_cause_in <= '0;
    tick(8);
    chk("auto restart", 1'b1, motor_enable);
    nonfatal_cause_in <= 4'h1;
    tick(4);
    chk("nonfatal runs", 1'b1, motor_enable);
    event_code <= 8'h77;
    event_strobe <= 1'b1;
    tick(1);
    event_strobe <= 1'b0;
    tick(2);
    chk("event msg", 8'h77, msg_id);
    tick(10);
    chk("msg back", CODE_NONFATAL + 8'h04, msg_id);
    inverter_type <= 1'b1;
    inverter_code <= 4'h9;
    inverter_fault <= 1'b1;
    tick(2);
    chk("inverter", 5'h19, inv_name_idx);
    inverter_fault <= 1'b0;
    rd(OFS_ERRIDX);
    h = rv;
    chk("list filled", 1'b1, h != 0);
    wr(OFS_CTRL, 32'h808);
    rc(OFS_ERRIDX, h);
    wr(OFS_CTRL, 32'h804);
    wr(OFS_CTRL, 32'h80c);
    rc(OFS_ERRIDX, '0);
    repeat (31) begin
      nonfatal_cause_in <= 4'h3;
      tick(2);
      nonfatal_cause_in <= 4'h1;
      push();
    end
    rc(OFS_ERRIDX, 32'(ERR_DEPTH));
    wr(OFS_ERRIDX, 32'h0);
    rc(OFS_ERRDAT, CODE_NONFATAL + 8'h05);
    results();
  end
endmodule : tb_top
